// File: core/pio_pkg.sv
package pio_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int NUM_PINS = 12;
    localparam int HI_PINS = 4;
    localparam int ADDR_W = 9;
    localparam int GROUP_SIZE = 4;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [8:0] ADDR_DEF_OUT_LO = 9'h10a;
    localparam logic [8:0] ADDR_DEF_OUT_HI = 9'h10b;
    localparam logic [8:0] ADDR_DEF_DIR_LO = 9'h10c;
    localparam logic [8:0] ADDR_DEF_DIR_HI = 9'h10d;
    localparam logic [8:0] ADDR_DEF_INV_LO = 9'h10e;
    localparam logic [8:0] ADDR_DEF_INV_HI = 9'h10f;
    localparam logic [8:0] ADDR_OUT_LO = 9'h120;
    localparam logic [8:0] ADDR_OUT_HI = 9'h121;
    localparam logic [8:0] ADDR_DIR_LO = 9'h122;
    localparam logic [8:0] ADDR_DIR_HI = 9'h123;
    localparam logic [8:0] ADDR_INV_LO = 9'h124;
    localparam logic [8:0] ADDR_INV_HI = 9'h125;
    localparam logic [8:0] ADDR_RDBK_LO = 9'h126;
    localparam logic [8:0] ADDR_RDBK_HI = 9'h127;

    // ----------------------------------------------------------------
    // field positions of the combined byte
    // ----------------------------------------------------------------
    localparam int TYPE_LSB = 4;
    localparam int TYPE_MSB = 6;
    localparam int DRIVE_BIT = 7;

    // ----------------------------------------------------------------
    // delivered default values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_DEF_OUT_LO = 8'hff;
    localparam logic [7:0] RST_DEF_OUT_HI = 8'h0f;
    localparam logic [7:0] RST_DEF_DIR_LO = 8'hff;
    localparam logic [7:0] RST_DEF_DIR_HI = 8'h0f;
    localparam logic [7:0] RST_DEF_INV_LO = 8'h00;
    localparam logic [7:0] RST_DEF_INV_HI = 8'h80;

    // ----------------------------------------------------------------
    // sequential switching timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_TRANS_NS = 1000;
    localparam int T_PAUSE_NS = 1000;
    localparam int TRANS_CYC = (T_TRANS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAUSE_CYC = (T_PAUSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // ----------------------------------------------------------------
    // state types
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        INIT_HIZ = 2'b00,
        INIT_LOAD = 2'b01,
        INIT_RUN = 2'b11
    } init_state_t;

    typedef enum logic [1:0]
    {
        SEQ_SCAN = 2'b00,
        SEQ_XFER = 2'b01,
        SEQ_PAUSE = 2'b11
    } seq_state_t;

endpackage

// File: core/pio_port.sv
`timescale 1ns/1ps
module pio_port
    import pio_pkg::*;
#(
    parameter int TRANS_CYCLES = TRANS_CYC,
    parameter int PAUSE_CYCLES = PAUSE_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic refresh_req,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic init_busy,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    // sequencer states
    init_state_t init_r;
    seq_state_t seq_r;

    // stored default bytes
    logic [NUM_PINS-1:0] def_level_r;
    logic [NUM_PINS-1:0] def_dir_r;
    logic [NUM_PINS-1:0] def_invert_r;
    logic [2:0] def_type_r;
    logic def_drive_r;

    // working registers
    logic [NUM_PINS-1:0] level_r;
    logic [NUM_PINS-1:0] dir_r;
    logic [NUM_PINS-1:0] invert_r;
    logic [2:0] type_r;
    logic drive_strength_r;

    // applied drive and sampled pins
    logic [NUM_PINS-1:0] app_out_r;
    logic [NUM_PINS-1:0] app_oe_r;
    logic [NUM_PINS-1:0] pin_meta_r;
    logic [NUM_PINS-1:0] pin_sync_r;

    // per-pin combinational values
    logic [NUM_PINS-1:0] want_out;
    logic [NUM_PINS-1:0] want_oe;
    logic [NUM_PINS-1:0] pin_val;
    logic [NUM_PINS-1:0] readback;

    // scanner and read path
    logic [3:0] idx_r;
    logic [CNT_W-1:0] cnt_r;
    logic [7:0] reg_rdata_r;
    logic [7:0] rd_nxt;

    // decode helpers
    logic run;
    logic idx_diff;
    logic seq_apply;
    logic [3:0] idx_next;

    // busy spans both the tri-state cycle and the load cycle
    assign run = (init_r == INIT_RUN);
    assign init_busy = ~run;

    // ----------------------------------------------------------------
    // start-up and refresh sequencing
    // ----------------------------------------------------------------
    // hiz first, then one load cycle, then normal operation
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            init_r <= INIT_HIZ;
        end
        else
        begin
            case (init_r)
                INIT_HIZ: init_r <= INIT_LOAD;
                INIT_LOAD: init_r <= INIT_RUN;
                INIT_RUN:
                begin
                    // a refresh pulse seen while busy is simply lost
                    if (refresh_req)
                    begin
                        init_r <= INIT_HIZ;
                    end
                end
                default: init_r <= INIT_HIZ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // default bytes
    // ----------------------------------------------------------------
    // rst stands for the delivered state; real storage would survive it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            def_level_r <= {RST_DEF_OUT_HI[HI_PINS-1:0], RST_DEF_OUT_LO};
            def_dir_r <= {RST_DEF_DIR_HI[HI_PINS-1:0], RST_DEF_DIR_LO};
            def_invert_r <= {RST_DEF_INV_HI[HI_PINS-1:0], RST_DEF_INV_LO};
            def_type_r <= RST_DEF_INV_HI[TYPE_MSB:TYPE_LSB];
            def_drive_r <= RST_DEF_INV_HI[DRIVE_BIT];
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                ADDR_DEF_OUT_LO: def_level_r[7:0] <= reg_wdata;
                ADDR_DEF_OUT_HI: def_level_r[11:8] <= reg_wdata[HI_PINS-1:0];
                ADDR_DEF_DIR_LO: def_dir_r[7:0] <= reg_wdata;
                ADDR_DEF_DIR_HI: def_dir_r[11:8] <= reg_wdata[HI_PINS-1:0];
                ADDR_DEF_INV_LO: def_invert_r[7:0] <= reg_wdata;
                ADDR_DEF_INV_HI:
                begin
                    def_invert_r[11:8] <= reg_wdata[HI_PINS-1:0];
                    def_type_r <= reg_wdata[TYPE_MSB:TYPE_LSB];
                    def_drive_r <= reg_wdata[DRIVE_BIT];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // working registers
    // ----------------------------------------------------------------
    // reset value is all-input so nothing drives before the load
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            level_r <= '0;
            dir_r <= '1;
            invert_r <= '0;
            type_r <= '0;
            drive_strength_r <= 1'b0;
        end
        else if (init_r == INIT_LOAD)
        begin
            level_r <= def_level_r;
            dir_r <= def_dir_r;
            invert_r <= def_invert_r;
            type_r <= def_type_r;
            drive_strength_r <= def_drive_r;
        end
        else if (run && reg_wr)
        begin
            // high nibble writes keep only bits 3:0, except ADDR_INV_HI, which also keeps the type and drive bits
            case (reg_addr)
                ADDR_OUT_LO: level_r[7:0] <= reg_wdata;
                ADDR_OUT_HI: level_r[11:8] <= reg_wdata[HI_PINS-1:0];
                ADDR_DIR_LO: dir_r[7:0] <= reg_wdata;
                ADDR_DIR_HI: dir_r[11:8] <= reg_wdata[HI_PINS-1:0];
                ADDR_INV_LO: invert_r[7:0] <= reg_wdata;
                ADDR_INV_HI:
                begin
                    invert_r[11:8] <= reg_wdata[HI_PINS-1:0];
                    type_r <= reg_wdata[TYPE_MSB:TYPE_LSB];
                    drive_strength_r <= reg_wdata[DRIVE_BIT];
                end
                default: ; // readback offsets ignore writes
            endcase
        end
    end

    // ----------------------------------------------------------------
    // per-pin wanted drive
    // ----------------------------------------------------------------
    generate
        for (genvar i = 0; i < NUM_PINS; i++)
        begin : g_pin
            // open drain only pulls low; input pins never drive
            assign want_oe[i] = ~dir_r[i] & (~type_r[i / GROUP_SIZE] | ~level_r[i]);
            assign want_out[i] = level_r[i];
            // a driven pin reads its own output state
            assign pin_val[i] = app_oe_r[i] ? app_out_r[i] : pin_sync_r[i];
        end
    endgenerate

    // inversion acts on the read path only, never on the drive
    assign readback = pin_val ^ invert_r;

    // ----------------------------------------------------------------
    // pin input synchroniser
    // ----------------------------------------------------------------
    // two flops before any logic looks at a pin
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end
        else
        begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // sequential switching engine
    // ----------------------------------------------------------------
    // an undriven pin shows no level, so only a visible change costs a slot
    assign idx_diff = (app_oe_r[idx_r] != want_oe[idx_r]) ||
                      (want_oe[idx_r] && (app_out_r[idx_r] != want_out[idx_r]));
    assign seq_apply = run && drive_strength_r && (seq_r == SEQ_SCAN) && idx_diff;
    assign idx_next = (idx_r == 4'(NUM_PINS - 1)) ? 4'h0 : idx_r + 4'h1;

    // one pin at a time: transition window then pause, then next pin
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            seq_r <= SEQ_SCAN;
            idx_r <= 4'h0;
            cnt_r <= '0;
        end
        // leaving sequential mode restarts the scan at pin 0
        else if (!run || !drive_strength_r)
        begin
            seq_r <= SEQ_SCAN;
            idx_r <= 4'h0;
            cnt_r <= '0;
        end
        else
        begin
            case (seq_r)
                SEQ_SCAN:
                begin
                    if (idx_diff)
                    begin
                        seq_r <= SEQ_XFER;
                        cnt_r <= CNT_W'(TRANS_CYCLES - 1);
                    end
                    else
                    begin
                        idx_r <= idx_next;
                    end
                end
                SEQ_XFER:
                begin
                    if (cnt_r == '0)
                    begin
                        seq_r <= SEQ_PAUSE;
                        cnt_r <= CNT_W'(PAUSE_CYCLES - 1);
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                SEQ_PAUSE:
                begin
                    if (cnt_r == '0)
                    begin
                        seq_r <= SEQ_SCAN;
                        idx_r <= idx_next;
                    end
                    else
                    begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: seq_r <= SEQ_SCAN;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // applied pin drive
    // ----------------------------------------------------------------
    // outside run every driver is released, so reload starts tri-stated
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            app_out_r <= '0;
            app_oe_r <= '0;
        end
        else if (!run)
        begin
            // level is left alone; with every enable low it is not seen
            app_oe_r <= '0;
        end
        else if (!drive_strength_r)
        begin
            app_out_r <= want_out;
            app_oe_r <= want_oe;
        end
        else if (seq_apply)
        begin
            app_out_r[idx_r] <= want_out[idx_r];
            app_oe_r[idx_r] <= want_oe[idx_r];
        end
    end

    assign pin_out = app_out_r;
    assign pin_oe = app_oe_r;

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    // plain decode; reserved and unmapped offsets read zero
    always_comb
    begin
        rd_nxt = 8'h00;
        case (reg_addr)
            ADDR_DEF_OUT_LO: rd_nxt = def_level_r[7:0];
            ADDR_DEF_OUT_HI: rd_nxt = {4'h0, def_level_r[11:8]};
            ADDR_DEF_DIR_LO: rd_nxt = def_dir_r[7:0];
            ADDR_DEF_DIR_HI: rd_nxt = {4'h0, def_dir_r[11:8]};
            ADDR_DEF_INV_LO: rd_nxt = def_invert_r[7:0];
            ADDR_DEF_INV_HI: rd_nxt = {def_drive_r, def_type_r, def_invert_r[11:8]};
            ADDR_OUT_LO: rd_nxt = level_r[7:0];
            ADDR_OUT_HI: rd_nxt = {4'h0, level_r[11:8]};
            ADDR_DIR_LO: rd_nxt = dir_r[7:0];
            ADDR_DIR_HI: rd_nxt = {4'h0, dir_r[11:8]};
            ADDR_INV_LO: rd_nxt = invert_r[7:0];
            ADDR_INV_HI: rd_nxt = {drive_strength_r, type_r, invert_r[11:8]};
            ADDR_RDBK_LO: rd_nxt = readback[7:0];
            ADDR_RDBK_HI: rd_nxt = {4'h0, readback[11:8]};
            default: rd_nxt = 8'h00;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata_r <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata_r <= rd_nxt;
        end
    end

    assign reg_rdata = reg_rdata_r;

endmodule

// File: sim/pio_port_asserts.sv
`timescale 1ns/1ps
module pio_port_asserts
    import pio_pkg::*;
#(
    parameter int TRANS_CYCLES = TRANS_CYC,
    parameter int PAUSE_CYCLES = PAUSE_CYC
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic refresh_req,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic init_busy,
    input wire logic [NUM_PINS-1:0] pin_in,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe
);
    // ----------------------------------------
    // mode shadow and pin change spacing
    // ----------------------------------------
    localparam int GAP = TRANS_CYCLES + PAUSE_CYCLES - 1;
    logic def_mode_r;
    logic mode_r;
    logic [15:0] gap_r;
    logic [2*NUM_PINS-1:0] prev_r;
    logic pin_chg;
    // undriven pin_out bits are masked, they carry no meaning
    assign pin_chg = ({pin_oe, pin_out & pin_oe} != prev_r);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // shadow of the stored mode bit
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            def_mode_r <= 1'b1;
        else if (reg_wr && reg_addr == ADDR_DEF_INV_HI)
            def_mode_r <= reg_wdata[DRIVE_BIT];
    end
    // working mode: reload copies the default, writes blocked while busy
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mode_r <= 1'b1;
        else if (init_busy)
            mode_r <= def_mode_r;
        else if (reg_wr && reg_addr == ADDR_INV_HI)
            mode_r <= reg_wdata[DRIVE_BIT];
    end
    // saturating gap count, set to its maximum outside sequential mode so a mode
    // switch never blames a simultaneous update
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            gap_r <= '1;
        else if (!mode_r || init_busy)
            gap_r <= '1;
        else if (pin_chg)
            gap_r <= '0;
        else if (gap_r != '1)
            gap_r <= gap_r + 16'h1;
    end
    // last masked pin state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            prev_r <= '0;
        else
            prev_r <= {pin_oe, pin_out & pin_oe};
    end
    a_reset_hiz: assert property ($past(rst) |-> (pin_oe == '0)[*3])
        else $error("pins driven right after reset");
    a_powerup_load: assert property ($past(rst) |->
        init_busy ##1 init_busy ##1 !init_busy)
        else $error("power-up load length wrong");
    a_refresh_start: assert property (refresh_req && !init_busy |=> init_busy)
        else $error("refresh not started");
    a_refresh_len: assert property ($rose(init_busy) |-> init_busy[*2] ##1 !init_busy)
        else $error("refresh length wrong");
    a_refresh_hiz: assert property ($rose(init_busy) |=> pin_oe == '0)
        else $error("pins driven during refresh");
    a_rdbk_hi_zero: assert property (reg_rd && reg_addr == ADDR_RDBK_HI |=>
        reg_rdata[7:4] == 4'h0)
        else $error("readback high nibble not zero");
    a_hi_bits_zero: assert property (reg_rd &&
        (reg_addr == ADDR_OUT_HI || reg_addr == ADDR_DIR_HI) |=> reg_rdata[7:4] == 4'h0)
        else $error("unassigned bits not zero");
    a_seq_gap_min: assert property (mode_r && !init_busy && pin_chg |-> gap_r >= GAP)
        else $error("sequential pins switched too close");
    c_refresh: cover property ($rose(init_busy));
    c_seq_change: cover property (mode_r && pin_chg);
    c_rdbk_read: cover property (reg_rd && reg_addr == ADDR_RDBK_LO);
endmodule

bind pio_port pio_port_asserts #(
    .TRANS_CYCLES(TRANS_CYCLES),
    .PAUSE_CYCLES(PAUSE_CYCLES)
) u_pio_port_asserts (
    .sys_clk(sys_clk), .rst(rst), .refresh_req(refresh_req), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .init_busy(init_busy), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
);

// File: sim/pin_board.sv
`timescale 1ns/1ps
module pin_board
(
    input wire logic [11:0] pin_out,
    input wire logic [11:0] pin_oe,
    input wire logic [11:0] ext_level,
    input wire logic [11:0] ext_drive,
    output logic [11:0] pin_in
);
    // ------------------------------
    // wire resolution
    // ------------------------------
    // device wins where it drives; a floating line goes to the pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive & ext_level) |
                    (~pin_oe & ~ext_drive);
endmodule

// File: sim/pio_port_tb.sv
`timescale 1ns/1ps
module pio_port_tb
    import pio_pkg::*;
;
    // ------------------------------
    // bench
    // ------------------------------
    logic sys_clk, rst, refresh_req, reg_wr, reg_rd, init_busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe, ext_level, ext_drive, lv, dir, inv, prev;
    logic [2:0] od;
    int mismatches = 0;
    int comparisons = 0;
    int n;
    logic [7:0] def_exp [6] = '{8'hff, 8'h0f, 8'hff, 8'h0f, 8'h00, 8'h80};
    logic [7:0] ref_exp [6] = '{8'h3c, 8'h01, 8'h00, 8'h0e, 8'h00, 8'h00};

    // short counts keep the sequential scan quick
    pio_port #(.TRANS_CYCLES(4), .PAUSE_CYCLES(4)) DUT (
        .sys_clk(sys_clk), .rst(rst), .refresh_req(refresh_req), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .init_busy(init_busy), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    pin_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .ext_drive(ext_drive), .pin_in(pin_in));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // every drive lands 1 ns after the edge
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pins(input string nm, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // idle cycle after each strobe so no signal is set twice in a step
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask
    task automatic rchk(input logic [8:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        step(1);
        reg_rd = 1'b0;
        rd_val = reg_rdata;
        step(1);
        chk_reg($sformatf("reg %h", a), e, rd_val);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 20; i++)
        begin
            if (init_busy === 1'b0)
                return;
            step(1);
        end
        chk_pins("init_busy", 12'h0, {11'h0, init_busy});
        stop_test();
    endtask
    function automatic logic [11:0] exp_oe(input logic [11:0] l, d, input logic [2:0] t);
        for (int i = 0; i < NUM_PINS; i++)
            exp_oe[i] = !d[i] && (!t[i / GROUP_SIZE] || !l[i]);
    endfunction
    // expected drive and readback from the bench's own pin picture
    task automatic check_pins();
        logic [11:0] oe;
        logic [11:0] rb;
        oe = exp_oe(lv, dir, od);
        for (int i = 0; i < NUM_PINS; i++)
            rb[i] = (oe[i] ? lv[i] : (ext_drive[i] ? ext_level[i] : 1'b1)) ^ inv[i];
        step(4);
        chk_pins("pin_oe", oe, pin_oe);
        chk_pins("pin_out", lv & oe, pin_out & pin_oe);
        rchk(ADDR_RDBK_LO, rb[7:0]);
        rchk(ADDR_RDBK_HI, {4'h0, rb[11:8]});
    endtask

    // hang guard
    initial
    begin
        step(20000);
        chk_pins("run length", 12'h0, 12'h1);
        stop_test();
    end

    initial
    begin
        {rst, refresh_req, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        rst = 1'b1;
        ext_level = 12'ha5c;
        ext_drive = 12'hfff;
        step(10);
        rst = 1'b0;
        wait_idle();
        for (int i = 0; i < 6; i++)
            rchk(ADDR_DEF_OUT_LO + 9'(i), def_exp[i]);
        for (int i = 0; i < 6; i++)
            rchk(ADDR_OUT_LO + 9'(i), def_exp[i]);
        {lv, dir, inv, od} = {12'hfff, 12'hfff, 12'h000, 3'h0};
        check_pins();
        $display("test defaults done");
        wr(ADDR_INV_HI, 8'h00);
        wr(ADDR_OUT_LO, 8'h5a);
        wr(ADDR_OUT_HI, 8'hf3);
        wr(ADDR_DIR_LO, 8'hf0);
        wr(ADDR_DIR_HI, 8'hfc);
        wr(ADDR_INV_LO, 8'h11);
        wr(ADDR_RDBK_LO, 8'hff);
        wr(ADDR_RDBK_HI, 8'hff);
        rchk(ADDR_OUT_HI, 8'h03);
        rchk(ADDR_DIR_HI, 8'h0c);
        rchk(9'h128, 8'h00);
        {lv, dir, inv, od} = {12'h35a, 12'hcf0, 12'h011, 3'h0};
        check_pins();
        $display("test simultaneous done");
        wr(ADDR_INV_HI, 8'h7f);
        ext_drive = 12'hff7;
        {inv, od} = {12'hf11, 3'h7};
        check_pins();
        $display("test open drain done");
        wr(ADDR_INV_HI, 8'h80);
        ext_drive = 12'hfff;
        {inv, od} = {12'h011, 3'h0};
        step(60);
        check_pins();
        prev = pin_out;
        n = 0;
        wr(ADDR_OUT_LO, 8'h55);
        for (int i = 0; i < 150; i++)
        begin
            if (pin_out[3:0] !== prev[3:0])
                n++;
            prev = pin_out;
            step(1);
        end
        chk_pins("switch steps", 12'h4, 12'(n));
        lv = 12'h355;
        check_pins();
        $display("test sequential done");
        wr(ADDR_INV_HI, 8'h00);
        wr(ADDR_OUT_LO, 8'h5a);
        step(1);
        chk_pins("together", {8'h0, 4'ha}, {8'h0, pin_out[3:0]});
        $display("test mode return done");
        wr(ADDR_DEF_OUT_LO, 8'h3c);
        wr(ADDR_DEF_OUT_HI, 8'hf1);
        wr(ADDR_DEF_DIR_LO, 8'h00);
        wr(ADDR_DEF_DIR_HI, 8'h0e);
        wr(ADDR_DEF_INV_HI, 8'h00);
        refresh_req = 1'b1;
        step(1);
        refresh_req = 1'b0;
        step(1);
        chk_pins("refresh oe", 12'h000, pin_oe);
        wait_idle();
        for (int i = 0; i < 6; i++)
            rchk(ADDR_OUT_LO + 9'(i), ref_exp[i]);
        {lv, dir, inv, od} = {12'h13c, 12'he00, 12'h000, 3'h0};
        check_pins();
        rst = 1'b1;
        step(3);
        rst = 1'b0;
        wait_idle();
        rchk(ADDR_DEF_OUT_LO, 8'hff);
        rchk(ADDR_DIR_LO, 8'hff);
        $display("test refresh done");
        stop_test();
    end
endmodule
